// *** hdl/port_io_params.svh ***
/*
 * Named register selects, field positions and reset values of the
 * dual handshake port block.
 * Assumes inclusion by its bare name from the design.
 */
`ifndef PORT_IO_PARAMS_SVH
`define PORT_IO_PARAMS_SVH

// Register selects
`define SEL_PORT_B        4'h0
`define SEL_PORT_A        4'h1
`define SEL_DIR_B         4'h2
`define SEL_DIR_A         4'h3
`define SEL_AUX_CTRL      4'hB
`define SEL_LINE_MODES    4'hC
`define SEL_IRQ_FLAGS     4'hD
`define SEL_IRQ_ENABLE    4'hE
`define SEL_PORT_A_QUIET  4'hF

// Interrupt flag bit positions
`define FLG_A_HS          0
`define FLG_A_STB         1
`define FLG_B_HS          3
`define FLG_B_STB         4
`define FLG_ANY           7

// Line mode field positions
`define MODE_A_EDGE       0
`define MODE_A_HS_LSB     1
`define MODE_B_EDGE       4
`define MODE_B_HS_LSB     5

// Handshake line mode code bit positions
`define HS_INDEP_BIT      0
`define HS_EDGE_BIT       1
`define HS_OUT_BIT        2

// Auxiliary control bit positions
`define AUX_LATCH_A       0
`define AUX_LATCH_B       1
`define AUX_PB7_TIMER     7

// Enable register set/clear bit, pin bits used by the timers
`define IER_SET_BIT       7
`define PB7_BIT           7
`define PB6_BIT           6

// Reset values and capture buffer depth
`define RST_BYTE          8'h00
`define RST_FLAGS         7'h00
`define RST_COUNT         2'h0
`define FIFO_DEPTH        2'h2

`endif

// *** hdl/port_io_pkg.sv ***
/*
 * Types shared by the dual handshake port block: bus request, line
 * mode codes and the complete state record.
 * Assumes the constants header sits beside it.
 */
package port_io_pkg;

   // Processor bus request in one bundle
   typedef struct packed {
      logic       select;    // Chip selected this cycle
      logic       read;      // 1 read, 0 write
      logic [3:0] reg_sel;   // Register select
      logic [7:0] wdata;     // Write data
   } bus_request_type;

   // Handshake line mode codes (three-bit field)
   typedef enum logic [2:0] {
      HS_IN_NEG       = 3'h0,
      HS_IN_NEG_INDEP = 3'h1,
      HS_IN_POS       = 3'h2,
      HS_IN_POS_INDEP = 3'h3,
      HS_HANDSHAKE    = 3'h4,
      HS_PULSE        = 3'h5,
      HS_LOW          = 3'h6,
      HS_HIGH         = 3'h7
   } hs_mode_type;

   // Whole state of the block
   typedef struct packed {
      logic [7:0]       port_a_output_latch;
      logic [7:0]       port_b_output_latch;
      logic [7:0]       port_a_direction;
      logic [7:0]       port_b_direction;
      logic [7:0]       auxiliary_control;
      logic [7:0]       control_line_modes;
      logic [6:0]       flags;
      logic [6:0]       enables;
      logic [1:0][7:0]  cap_mem;       // Two-entry port A capture buffer
      logic             cap_head;
      logic [1:0]       cap_count;
      logic [7:0]       port_b_input_latch;
      logic             prev_a_strobe;
      logic             prev_a_hs;
      logic             prev_b_strobe;
      logic             prev_b_hs;
      logic             prev_pb6;
      logic             a_hs_level;
      logic             b_hs_level;
      logic [7:0]       pa_drive;
      logic [7:0]       pb_drive;
      logic [7:0]       pb_oe;
      logic             a_hs_oe;
      logic             b_hs_oe;
      logic [7:0]       rdata;
      logic             rdata_oe;
      logic             irq_oe;
      logic             pb6_pulse;
      logic             cap_ready;
   } state_type;

endpackage

// *** hdl/dual_port_handshake_io.sv ***
/*
 * Two 8-bit peripheral ports with direction control, output latches,
 * edge-latched inputs, four control lines with interrupt flags, and
 * automatic read/write handshaking. Port A strobe captures pass
 * through a two-entry buffer; a third capture before a read is lost.
 * Assumes a processor bus request synchronous to clock_in, pins
 * synchronous to clock_in, and a timer block outside that supplies
 * the bit-7 timer level and takes the bit-6 pulse.
 */
`timescale 1ns/100ps

`include "port_io_params.svh"

// Behaviour
// - Direction bit 0 releases the pin
// - Direction bit 1 drives the pin
// - Driven pin follows its output latch bit
// - Latch writes stored, pin waits for direction
// - Port read returns its input register
// - Latch off: port A read shows pins
// - Active strobe edge captures port A pins
// - After the read emptying the buffer, port A input turns transparent
// - Port B outputs read latch, A reads pin
// - Port B latched inputs read strobe-time level
// - Port A latched reads captured level while buffered
// - Each control line in input mode sets its flag, enabled or not
// - Port A strobe line is input only
// - Handshake: A read/write, B write only
// - Data-ready strobe sets pollable flag
// - Data-taken output pulse or cleared level
// - Data-ready output cleared by taken edge
// - Line modes come from mode register
// - Latch enables come from auxiliary control
// - Bit 7 timer output, bit 6 pulse feed
// - Interrupt request when enabled flag set
// - Reset clears registers, pins inputs, no interrupt
// - Select 15 acts as port A, no handshake
module dual_port_handshake_io
   import port_io_pkg::*;
(
   input  wire logic            clock_in,
   input  wire logic            rst_n_in,
   input  wire bus_request_type cpu_bus_in,
   output logic [7:0]           cpu_rdata_out,
   output logic                 cpu_rdata_oe_out,
   input  wire logic [7:0]      port_a_pins_in,
   output logic [7:0]           port_a_pins_out,
   output logic [7:0]           port_a_pins_oe_out,
   input  wire logic [7:0]      port_b_pins_in,
   output logic [7:0]           port_b_pins_out,
   output logic [7:0]           port_b_pins_oe_out,
   input  wire logic            port_a_strobe_in,
   input  wire logic            port_a_handshake_line_in,
   output logic                 port_a_handshake_line_out,
   output logic                 port_a_handshake_line_oe_out,
   input  wire logic            port_b_strobe_in,
   input  wire logic            port_b_handshake_line_in,
   output logic                 port_b_handshake_line_out,
   output logic                 port_b_handshake_line_oe_out,
   input  wire logic            port_b_bit7_timer_out_in,
   output logic                 port_b_bit6_pulse_out,
   output logic                 port_a_capture_ready_out,
   output logic                 irq_n_out,
   output logic                 irq_n_oe_out
);

   state_type state_q;   // Registered state
   state_type state_d;   // Next state

   // Edge match: rising when pos is set, falling otherwise
   function automatic logic edge_hit(input logic prev, input logic now,
                                     input logic pos);
      edge_hit = pos ? (!prev && now) : (prev && !now);
   endfunction

   // Handshake line output level for a given mode and handshake level
   function automatic logic hs_out(input hs_mode_type mode, input logic lvl);
      unique case (mode)
         HS_LOW:  hs_out = 1'b0;
         HS_HIGH: hs_out = 1'b1;
         default: hs_out = lvl;
      endcase
   endfunction

   // Next-state logic
   always_comb begin
      logic        acc_a;        // Handshaking port A access
      logic        acc_a_any;    // Any port A data access
      logic        acc_b;        // Port B data access
      logic        wr;
      logic        rd;
      logic        a_stb_edge;
      logic        a_hs_edge;
      logic        b_stb_edge;
      logic        b_hs_edge;
      logic        pop;
      logic        push;
      logic [7:0]  ra;
      logic [7:0]  rb;
      logic [7:0]  pb_val;
      logic [6:0]  set_f;
      logic [6:0]  clr_f;
      logic [1:0]  cnt;
      hs_mode_type ma;
      hs_mode_type mb;

      state_d    = state_q;
      wr         = cpu_bus_in.select && !cpu_bus_in.read;
      rd         = cpu_bus_in.select && cpu_bus_in.read;
      acc_a_any  = cpu_bus_in.select && ((cpu_bus_in.reg_sel == `SEL_PORT_A) ||
                   (cpu_bus_in.reg_sel == `SEL_PORT_A_QUIET));
      acc_a      = cpu_bus_in.select && (cpu_bus_in.reg_sel == `SEL_PORT_A);
      acc_b      = cpu_bus_in.select && (cpu_bus_in.reg_sel == `SEL_PORT_B);
      ma         = hs_mode_type'(state_q.control_line_modes[`MODE_A_HS_LSB +: 3]);
      mb         = hs_mode_type'(state_q.control_line_modes[`MODE_B_HS_LSB +: 3]);

      // Edge detection against last cycle's sampled levels
      a_stb_edge = edge_hit(state_q.prev_a_strobe, port_a_strobe_in,
                            state_q.control_line_modes[`MODE_A_EDGE]);
      b_stb_edge = edge_hit(state_q.prev_b_strobe, port_b_strobe_in,
                            state_q.control_line_modes[`MODE_B_EDGE]);
      a_hs_edge  = !ma[`HS_OUT_BIT] && edge_hit(state_q.prev_a_hs,
                   port_a_handshake_line_in, ma[`HS_EDGE_BIT]);
      b_hs_edge  = !mb[`HS_OUT_BIT] && edge_hit(state_q.prev_b_hs,
                   port_b_handshake_line_in, mb[`HS_EDGE_BIT]);
      state_d.prev_a_strobe = port_a_strobe_in;
      state_d.prev_b_strobe = port_b_strobe_in;
      state_d.prev_a_hs     = port_a_handshake_line_in;
      state_d.prev_b_hs     = port_b_handshake_line_in;

      // Port A capture buffer: push on latching strobe edge, pop on read
      push = a_stb_edge && state_q.auxiliary_control[`AUX_LATCH_A];
      pop  = rd && acc_a_any && (state_q.cap_count != `RST_COUNT);
      cnt  = state_q.cap_count;
      if (pop) begin
         state_d.cap_head = !state_q.cap_head;
         cnt              = cnt - 2'h1;
      end
      if (push && (state_q.cap_count != `FIFO_DEPTH || pop)) begin
         // Tail slot from the count before any pop, so a pop and push never collide
         state_d.cap_mem[state_q.cap_head ^ state_q.cap_count[0]] = port_a_pins_in;
         cnt = cnt + 2'h1;
      end
      state_d.cap_count = cnt;
      state_d.cap_ready = (cnt != `FIFO_DEPTH);
      if (!state_q.auxiliary_control[`AUX_LATCH_A]) begin
         state_d.cap_count = `RST_COUNT;
         state_d.cap_ready = 1'b1;
      end

      // Port B input latch on its strobe edge
      if (b_stb_edge && state_q.auxiliary_control[`AUX_LATCH_B]) begin
         state_d.port_b_input_latch = port_b_pins_in;
      end

      // Read values
      ra = (state_q.cap_count != `RST_COUNT) ?
           state_q.cap_mem[state_q.cap_head] : port_a_pins_in;
      for (int i = 0; i < 8; i++) begin
         if (state_q.port_b_direction[i]) begin
            rb[i] = state_q.port_b_output_latch[i];
         end else if (state_q.auxiliary_control[`AUX_LATCH_B]) begin
            rb[i] = state_q.port_b_input_latch[i];
         end else begin
            rb[i] = port_b_pins_in[i];
         end
      end

      // Register reads, answered one cycle after the request
      state_d.rdata_oe = rd;
      if (rd) begin
         unique case (cpu_bus_in.reg_sel)
            `SEL_PORT_B:       state_d.rdata = rb;
            `SEL_PORT_A:       state_d.rdata = ra;
            `SEL_PORT_A_QUIET: state_d.rdata = ra;
            `SEL_DIR_B:        state_d.rdata = state_q.port_b_direction;
            `SEL_DIR_A:        state_d.rdata = state_q.port_a_direction;
            `SEL_AUX_CTRL:     state_d.rdata = state_q.auxiliary_control;
            `SEL_LINE_MODES:   state_d.rdata = state_q.control_line_modes;
            `SEL_IRQ_FLAGS:    state_d.rdata = {|(state_q.flags & state_q.enables),
                                                state_q.flags};
            `SEL_IRQ_ENABLE:   state_d.rdata = {1'b1, state_q.enables};
            default:           state_d.rdata = `RST_BYTE;
         endcase
      end

      // Register writes
      clr_f = `RST_FLAGS;
      if (wr) begin
         unique case (cpu_bus_in.reg_sel)
            `SEL_PORT_B:       state_d.port_b_output_latch = cpu_bus_in.wdata;
            `SEL_PORT_A:       state_d.port_a_output_latch = cpu_bus_in.wdata;
            `SEL_PORT_A_QUIET: state_d.port_a_output_latch = cpu_bus_in.wdata;
            `SEL_DIR_B:        state_d.port_b_direction = cpu_bus_in.wdata;
            `SEL_DIR_A:        state_d.port_a_direction = cpu_bus_in.wdata;
            `SEL_AUX_CTRL:     state_d.auxiliary_control = cpu_bus_in.wdata;
            `SEL_LINE_MODES:   state_d.control_line_modes = cpu_bus_in.wdata;
            `SEL_IRQ_FLAGS:    clr_f = cpu_bus_in.wdata[6:0];
            `SEL_IRQ_ENABLE: begin
               if (cpu_bus_in.wdata[`IER_SET_BIT]) begin
                  state_d.enables = state_q.enables | cpu_bus_in.wdata[6:0];
               end else begin
                  state_d.enables = state_q.enables & ~cpu_bus_in.wdata[6:0];
               end
            end
            default: ;
         endcase
      end

      // Data access clears strobe flags, handshake flags unless independent
      if (acc_a_any) begin
         clr_f[`FLG_A_STB] = 1'b1;
         if (!ma[`HS_INDEP_BIT] || ma[`HS_OUT_BIT]) begin
            clr_f[`FLG_A_HS] = 1'b1;
         end
      end
      if (acc_b) begin
         clr_f[`FLG_B_STB] = 1'b1;
         if (!mb[`HS_INDEP_BIT] || mb[`HS_OUT_BIT]) begin
            clr_f[`FLG_B_HS] = 1'b1;
         end
      end

      // Flag setting: a new edge wins over a clear in the same cycle
      set_f               = `RST_FLAGS;
      set_f[`FLG_A_STB]   = a_stb_edge;
      set_f[`FLG_A_HS]    = a_hs_edge;
      set_f[`FLG_B_STB]   = b_stb_edge;
      set_f[`FLG_B_HS]    = b_hs_edge;
      state_d.flags       = (state_q.flags & ~clr_f) | set_f;
      state_d.irq_oe      = |(state_d.flags & state_d.enables);

      // Port A handshake line: read and write handshaking
      if (ma == HS_HANDSHAKE) begin
         if (acc_a) begin
            state_d.a_hs_level = 1'b0;
         end else if (a_stb_edge) begin
            state_d.a_hs_level = 1'b1;
         end
      end else if (ma == HS_PULSE) begin
         state_d.a_hs_level = !acc_a;
      end else begin
         state_d.a_hs_level = 1'b1;
      end

      // Port B handshake line: write handshaking only
      if (mb == HS_HANDSHAKE) begin
         if (acc_b && wr) begin
            state_d.b_hs_level = 1'b0;
         end else if (b_stb_edge) begin
            state_d.b_hs_level = 1'b1;
         end
      end else if (mb == HS_PULSE) begin
         state_d.b_hs_level = !(acc_b && wr);
      end else begin
         state_d.b_hs_level = 1'b1;
      end
      // Enables follow the new mode at once, so a line set to input is freed with it
      state_d.a_hs_oe = state_d.control_line_modes[`MODE_A_HS_LSB + `HS_OUT_BIT];
      state_d.b_hs_oe = state_d.control_line_modes[`MODE_B_HS_LSB + `HS_OUT_BIT];

      // Pin drivers follow the next register values
      state_d.pa_drive = state_d.port_a_output_latch;
      pb_val           = state_d.port_b_output_latch;
      if (state_d.auxiliary_control[`AUX_PB7_TIMER]) begin
         pb_val[`PB7_BIT] = port_b_bit7_timer_out_in;
      end
      state_d.pb_drive = pb_val;
      state_d.pb_oe    = state_d.port_b_direction;

      // Falling edge on bit 6 feeds the pulse counter
      state_d.prev_pb6  = port_b_pins_in[`PB6_BIT];
      state_d.pb6_pulse = state_q.prev_pb6 && !port_b_pins_in[`PB6_BIT];

      // Synchronous reset clears everything but the ready and handshake levels, which go high, all lines become inputs
      if (!rst_n_in) begin
         state_d           = '0;
         state_d.cap_ready = 1'b1;
         state_d.a_hs_level = 1'b1;
         state_d.b_hs_level = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clock_in) begin
      state_q <= state_d;
   end

   // Outputs from state flip-flops; handshake lines via hs_out, interrupt line tied low
   assign cpu_rdata_out                = state_q.rdata;
   assign cpu_rdata_oe_out             = state_q.rdata_oe;
   assign port_a_pins_out              = state_q.pa_drive;
   assign port_a_pins_oe_out           = state_q.port_a_direction;
   assign port_b_pins_out              = state_q.pb_drive;
   assign port_b_pins_oe_out           = state_q.pb_oe;
   assign port_a_handshake_line_out    = hs_out(hs_mode_type'(
      state_q.control_line_modes[`MODE_A_HS_LSB +: 3]), state_q.a_hs_level);
   assign port_a_handshake_line_oe_out = state_q.a_hs_oe;
   assign port_b_handshake_line_out    = hs_out(hs_mode_type'(
      state_q.control_line_modes[`MODE_B_HS_LSB +: 3]), state_q.b_hs_level);
   assign port_b_handshake_line_oe_out = state_q.b_hs_oe;
   assign port_b_bit6_pulse_out        = state_q.pb6_pulse;
   assign port_a_capture_ready_out     = state_q.cap_ready;
   assign irq_n_out                    = 1'b0;
   assign irq_n_oe_out                 = state_q.irq_oe;

endmodule

// *** testbench/port_io_sva.sv ***
/* Checker of bus answers, pin enables and handshake line timing.
   Assumes binding to the port block and sight of its ports only. */
`timescale 1ns/100ps
module port_io_sva
   import port_io_pkg::*;
(
   input wire logic            clock_in,
   input wire logic            rst_n_in,
   input wire bus_request_type cpu_bus_in,
   input wire logic            cpu_rdata_oe_out,
   input wire logic [7:0]      port_a_pins_out,
   input wire logic [7:0]      port_a_pins_oe_out,
   input wire logic [7:0]      port_b_pins_oe_out,
   input wire logic            port_a_handshake_line_out,
   input wire logic            port_a_handshake_line_oe_out,
   input wire logic            port_b_handshake_line_out,
   input wire logic            irq_n_out,
   input wire logic            irq_n_oe_out
);
   logic [7:0] modes_q;                                      // Shadow of the line mode register
   wire        wr = cpu_bus_in.select && !cpu_bus_in.read;   // Write taken this edge
   wire        rd = cpu_bus_in.select && cpu_bus_in.read;    // Read taken this edge
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // Follow mode register writes so line checks know the mode
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         modes_q <= 8'h00;
      end else if (wr && cpu_bus_in.reg_sel == 4'hC) begin
         modes_q <= cpu_bus_in.wdata;
      end
   end
   // Line low for one cycle, then back high
   sequence low_one_seq(line);
      !line ##1 line;
   endsequence
   read_answer_a: assert property (rd |=> cpu_rdata_oe_out)
      else $error("read answer missing");
   quiet_bus_a: assert property (!rd |=> !cpu_rdata_oe_out)
      else $error("read answer without read");
   dir_a_a: assert property (wr && cpu_bus_in.reg_sel == 4'h3 |=>
      port_a_pins_oe_out == $past(cpu_bus_in.wdata)) else $error("port A enable wrong");
   dir_b_a: assert property (wr && cpu_bus_in.reg_sel == 4'h2 |=>
      port_b_pins_oe_out == $past(cpu_bus_in.wdata)) else $error("port B enable wrong");
   drive_value_a: assert property (wr && cpu_bus_in.reg_sel == 4'h1 |=>
      (port_a_pins_out & port_a_pins_oe_out) == ($past(cpu_bus_in.wdata) & port_a_pins_oe_out))
      else $error("port A drive wrong");
   pulse_taken_a: assert property (wr && cpu_bus_in.reg_sel == 4'h1 && modes_q[3:1] == 3'h5
      |=> low_one_seq(port_a_handshake_line_out)) else $error("pulse not one cycle");
   quiet_select_a: assert property (cpu_bus_in.select && cpu_bus_in.reg_sel == 4'hF &&
      modes_q[3:2] == 2'b10 && port_a_handshake_line_out |=> port_a_handshake_line_out)
      else $error("select 15 made a handshake");
   b_write_a: assert property (wr && cpu_bus_in.reg_sel == 4'h0 && modes_q[7:5] == 3'h4
      |=> !port_b_handshake_line_out) else $error("port B data ready missing");
   line_enable_a: assert property (port_a_handshake_line_oe_out == modes_q[3])
      else $error("port A line enable not following its mode");
   irq_drain_a: assert property (irq_n_out == 1'b0)
      else $error("interrupt line drives high");
   reset_clear_a: assert property (disable iff (1'b0) !rst_n_in |=>
      port_a_pins_oe_out == 8'h00 && port_b_pins_oe_out == 8'h00 && !irq_n_oe_out)
      else $error("reset left an output enabled");
endmodule
bind dual_port_handshake_io port_io_sva u_port_io_sva (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .cpu_bus_in(cpu_bus_in),
   .cpu_rdata_oe_out(cpu_rdata_oe_out), .port_a_pins_out(port_a_pins_out),
   .port_a_pins_oe_out(port_a_pins_oe_out), .port_b_pins_oe_out(port_b_pins_oe_out),
   .port_a_handshake_line_out(port_a_handshake_line_out),
   .port_a_handshake_line_oe_out(port_a_handshake_line_oe_out),
   .port_b_handshake_line_out(port_b_handshake_line_out),
   .irq_n_out(irq_n_out), .irq_n_oe_out(irq_n_oe_out));

// *** testbench/peripheral_model.sv ***
/* Peripheral on the far side: drives both ports and the strobes,
   answers a falling handshake line with new data and a strobe.
   Assumes the bench resolves the pins and pulls the lines up. */
`timescale 1ns/100ps
module peripheral_model (
   input  wire logic       clock_in,
   input  wire logic       a_line_in,
   input  wire logic       b_line_in,
   output logic [7:0]      pa_drive_out,
   output logic [7:0]      pb_drive_out,
   output logic            a_strobe_out,
   output logic            b_strobe_out
);
   // Idle: strobes high, data zero
   initial begin
      pa_drive_out = 8'h00;
      pb_drive_out = 8'h00;
      a_strobe_out = 1'b1;
      b_strobe_out = 1'b1;
   end
   // Present data, then a falling strobe held two cycles
   task automatic strobe(input bit port_b, input logic [7:0] data);
      @(negedge clock_in);
      if (port_b) pb_drive_out = data; else pa_drive_out = data;
      repeat (2) @(negedge clock_in);
      if (port_b) b_strobe_out = 1'b0; else a_strobe_out = 1'b0;
      repeat (2) @(negedge clock_in);
      if (port_b) b_strobe_out = 1'b1; else a_strobe_out = 1'b1;
   endtask
   // Data taken or data ready seen: reply with the next byte
   always @(negedge a_line_in) strobe(1'b0, pa_drive_out + 8'h01);
   always @(negedge b_line_in) strobe(1'b1, pb_drive_out + 8'h01);
endmodule

// *** testbench/dual_port_handshake_io_tb.sv ***
/* Self-checking bench of the dual handshake port block.
   Assumes the design, its package and the peripheral model. */
`timescale 1ns/100ps
module dual_port_handshake_io_tb;
   import port_io_pkg::*;
   logic            clock_in = 1'b0;    // 50 MHz clock
   logic            rst_n_in = 1'b0;    // Synchronous reset
   bus_request_type bus = '0;           // Processor request
   logic            timer_in = 1'b0;    // Bit-7 timer level
   logic [7:0]      rdata, pa_out, pa_oe, pb_out, pb_oe, pa_drv, pb_drv;
   logic            rdata_oe, a_hs_out, a_hs_oe, b_hs_out, b_hs_oe, a_stb, b_stb;
   logic            pulse6, cap_ready, irq_n, irq_oe;
   int              err_total = 0;
   int              cmp_count = 0;
   int              cycles = 0;
   wire [7:0]       pa_wire = (pa_oe & pa_out) | (~pa_oe & pa_drv);
   wire [7:0]       pb_wire = (pb_oe & pb_out) | (~pb_oe & pb_drv);
   wire             a_line = a_hs_oe ? a_hs_out : 1'b1;   // Pull-up when released
   wire             b_line = b_hs_oe ? b_hs_out : 1'b1;
   dual_port_handshake_io u_dual_port_handshake_io (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .cpu_bus_in(bus),
      .cpu_rdata_out(rdata), .cpu_rdata_oe_out(rdata_oe),
      .port_a_pins_in(pa_wire), .port_a_pins_out(pa_out), .port_a_pins_oe_out(pa_oe),
      .port_b_pins_in(pb_wire), .port_b_pins_out(pb_out), .port_b_pins_oe_out(pb_oe),
      .port_a_strobe_in(a_stb), .port_a_handshake_line_in(a_line),
      .port_a_handshake_line_out(a_hs_out), .port_a_handshake_line_oe_out(a_hs_oe),
      .port_b_strobe_in(b_stb), .port_b_handshake_line_in(b_line),
      .port_b_handshake_line_out(b_hs_out), .port_b_handshake_line_oe_out(b_hs_oe),
      .port_b_bit7_timer_out_in(timer_in), .port_b_bit6_pulse_out(pulse6),
      .port_a_capture_ready_out(cap_ready), .irq_n_out(irq_n), .irq_n_oe_out(irq_oe));
   peripheral_model u_peripheral_model (
      .clock_in(clock_in), .a_line_in(a_line), .b_line_in(b_line),
      .pa_drive_out(pa_drv), .pb_drive_out(pb_drv),
      .a_strobe_out(a_stb), .b_strobe_out(b_stb));
   // Clock generator
   initial begin
      forever #10 clock_in = ~clock_in;
   end
   // Compare and count
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One register write, released after the taking edge
   task automatic wr(input logic [3:0] sel, input logic [7:0] d);
      @(negedge clock_in);
      bus = '{1'b1, 1'b0, sel, d};
      @(negedge clock_in);
      bus.select = 1'b0;
   endtask
   // One register read, answer judged in the following cycle
   task automatic rd(input logic [3:0] sel, input logic [7:0] exp);
      @(negedge clock_in);
      bus = '{1'b1, 1'b1, sel, 8'h00};
      @(negedge clock_in);
      bus.select = 1'b0;
      check({7'h00, rdata_oe}, 8'h01);
      check(rdata, exp);
   endtask
   // Bounded wait for a handshake line to return high
   task automatic wait_high(input bit port_b);
      for (int i = 0; i < 12; i++) begin
         if ((port_b ? b_hs_out : a_hs_out) === 1'b1) break;
         @(negedge clock_in);
      end
   endtask
   // Registers and pins after reset
   task automatic t_reset;
      rd(4'h3, 8'h00);
      rd(4'hC, 8'h00);
      check(pa_oe | pb_oe, 8'h00);
      wr(4'h5, 8'hFF);
      rd(4'h5, 8'h00);
   endtask
   // Direction, output latch and port reads
   task automatic t_ports;
      wr(4'h1, 8'hA5);
      check(pa_oe, 8'h00);
      wr(4'h3, 8'hF0);
      check(pa_out & pa_oe, 8'hA0);
      wr(4'h2, 8'h0F);
      wr(4'h0, 8'h3C);
      u_peripheral_model.pa_drive_out = 8'h5A;
      u_peripheral_model.pb_drive_out = 8'h5A;
      rd(4'h0, 8'h5C);
      rd(4'h1, 8'hAA);
   endtask
   // Port A capture buffer filled past full, then drained
   task automatic t_latch;
      wr(4'h3, 8'h00);
      wr(4'hB, 8'h01);
      wr(4'hE, 8'h82);
      wr(4'hC, 8'h00);
      u_peripheral_model.strobe(1'b0, 8'h31);
      u_peripheral_model.strobe(1'b0, 8'h32);
      check({7'h00, irq_oe}, 8'h01);
      rd(4'hD, 8'h82);
      u_peripheral_model.strobe(1'b0, 8'h33);
      check({7'h00, cap_ready}, 8'h00);
      rd(4'hF, 8'h31);
      rd(4'h1, 8'h32);
      u_peripheral_model.pa_drive_out = 8'h44;
      rd(4'h1, 8'h44);
      wr(4'hB, 8'h02);
      wr(4'h2, 8'h00);
      u_peripheral_model.strobe(1'b1, 8'h77);
      u_peripheral_model.pb_drive_out = 8'h66;
      rd(4'h0, 8'h77);
      wr(4'hB, 8'h00);
   endtask
   // Handshake lines: every mode code, pulse, level, port B write
   task automatic t_handshake;
      for (int c = 0; c < 8; c++) begin
         wr(4'hC, {4'h0, c[2:0], 1'b0});
         check({7'h00, a_hs_oe}, {7'h00, c[2]});
         if (c >= 6) check({7'h00, a_hs_out}, {7'h00, c[0]});
      end
      wr(4'hC, 8'h0A);
      wr(4'h1, 8'h00);
      check({7'h00, a_hs_out}, 8'h00);
      repeat (12) @(negedge clock_in);
      wr(4'hC, 8'h88);
      check({7'h00, b_hs_oe}, 8'h01);
      rd(4'h1, 8'h46);
      check({7'h00, a_hs_out}, 8'h00);
      wait_high(1'b0);
      check({7'h00, a_hs_out}, 8'h01);
      rd(4'hF, 8'h47);
      check({7'h00, a_hs_out}, 8'h01);
      rd(4'h0, 8'h66);
      check({7'h00, b_hs_out}, 8'h01);
      wr(4'h0, 8'h00);
      check({7'h00, b_hs_out}, 8'h00);
      wait_high(1'b1);
      check({7'h00, b_hs_out}, 8'h01);
   endtask
   // Bit 7 timer drive and bit 6 falling-edge pulse
   task automatic t_timer;
      wr(4'hB, 8'h80);
      wr(4'h2, 8'h80);
      timer_in = 1'b1;
      repeat (2) @(negedge clock_in);
      check(pb_out & 8'h80, 8'h80);
      u_peripheral_model.pb_drive_out = 8'h00;
      for (int i = 0; i < 4 && pulse6 !== 1'b1; i++) @(negedge clock_in);
      check({7'h00, pulse6}, 8'h01);
   endtask
   // Counts, then the verdict
   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         complete_run();
      end
   end
   // Main sequence
   initial begin
      repeat (6) @(negedge clock_in);
      rst_n_in = 1'b1;
      t_reset();
      t_ports();
      t_latch();
      t_handshake();
      t_timer();
      complete_run();
   end
endmodule
